// ==== hdl/dacc_defines.svh ====
// Constants for the DSP accumulator register block
`ifndef DACC_DEFINES_SVH
`define DACC_DEFINES_SVH

// ----------------------------------------------------------------------
// Widths and field positions
// ----------------------------------------------------------------------
`define DACC_ACC_W 64
`define DACC_WORD_W 32
`define DACC_HI_MSB 63
`define DACC_HI_LSB 32
`define DACC_LO_MSB 31
`define DACC_LO_LSB 0
`define DACC_MID_MSB 47
`define DACC_MID_LSB 16

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DACC_ACC_RST 64'h0000_0000_0000_0000
`define DACC_WORD_RST 32'h0000_0000

`endif

// ==== hdl/dacc_pkg.sv ====
// Types shared by the DSP accumulator register block
package dacc_pkg;

  // --------------------------------------------------------------------
  // Operation codes presented by the execution stage
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    DACC_OP_NONE,
    DACC_OP_PRODUCT,
    DACC_OP_WR_HIGH,
    DACC_OP_WR_LOW,
    DACC_OP_RD_HIGH,
    DACC_OP_RD_MIDDLE
  } dacc_op_t;

  // Which product instruction delivered a result
  typedef enum logic [2:0] {
    DACC_PR_SIGNED_WIDE,
    DACC_PR_UNSIGNED_WIDE,
    DACC_PR_FLOAT,
    DACC_PR_PLAIN,
    DACC_PR_REPEAT_SOP
  } dacc_prod_t;

endpackage : dacc_pkg

// ==== hdl/dacc_slice.sv ====
// Slice extraction for accumulator reads
`include "dacc_defines.svh"

module dacc_slice
  import dacc_pkg::*;
(
  // Accumulator contents
  input wire logic [63:0] acc_i,
  // Read selection: high or middle
  input wire logic sel_mid_i,
  // Selected 32-bit slice
  output logic [31:0] slice_o
);

  // ----------------------------------------------------------------------
  // Slice select
  // ----------------------------------------------------------------------
  // Middle slice or upper half, never modifies the source
  always_comb begin
    if (sel_mid_i) begin
      slice_o = acc_i[`DACC_MID_MSB:`DACC_MID_LSB];
    end else begin
      slice_o = acc_i[`DACC_HI_MSB:`DACC_HI_LSB];
    end
  end

endmodule : dacc_slice

// ==== hdl/dacc_top.sv ====
// DSP accumulator register with move and product update paths
`include "dacc_defines.svh"

module dacc_top
  import dacc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Operation request from the execution stage
  input wire logic op_valid_i,
  input wire dacc_op_t op_i,
  input wire dacc_prod_t prod_kind_i,
  // Operand for half writes
  input wire logic [31:0] src_data_i,
  // Full product result from the multiply datapath
  input wire logic [63:0] prod_data_i,
  // Current accumulator value for the multiply datapath
  output logic [63:0] dsp_accumulator_o,
  // Read answer to the destination general register
  output logic [31:0] rd_data_o,
  output logic rd_valid_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [63:0] acc_reg; // The accumulator itself
  logic [63:0] acc_next;
  logic [31:0] rd_data_reg; // Registered read answer
  logic [31:0] rd_data_next;
  logic rd_valid_reg; // Answer strobe
  logic rd_valid_next;
  logic [31:0] slice; // Selected read slice

  // Decoded request strobes
  logic do_prod;
  logic do_wr_hi;
  logic do_wr_lo;
  logic do_rd;

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  // True for either read of the accumulator
  function automatic logic is_read_op(input dacc_op_t op);
    is_read_op = (op == DACC_OP_RD_HIGH) || (op == DACC_OP_RD_MIDDLE);
  endfunction : is_read_op

  // ----------------------------------------------------------------------
  // Read slice selector
  // ----------------------------------------------------------------------
  dacc_slice u_slice (
    .acc_i(acc_reg),
    .sel_mid_i(op_i == DACC_OP_RD_MIDDLE),
    .slice_o(slice)
  );

  // ----------------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------------
  // One strobe per operation class
  always_comb begin
    do_prod = op_valid_i && (op_i == DACC_OP_PRODUCT);
    do_wr_hi = op_valid_i && (op_i == DACC_OP_WR_HIGH);
    do_wr_lo = op_valid_i && (op_i == DACC_OP_WR_LOW);
    do_rd = op_valid_i && is_read_op(op_i);
  end

  // ----------------------------------------------------------------------
  // Accumulator next value
  // ----------------------------------------------------------------------
  // Any product kind replaces the whole value; half writes merge
  always_comb begin
    acc_next = acc_reg;
    if (do_prod) begin
      acc_next = prod_data_i;
    end else if (do_wr_hi) begin
      acc_next = {src_data_i, acc_reg[`DACC_LO_MSB:`DACC_LO_LSB]};
    end else if (do_wr_lo) begin
      acc_next = {acc_reg[`DACC_HI_MSB:`DACC_HI_LSB], src_data_i};
    end
  end

  // ----------------------------------------------------------------------
  // Read answer next value
  // ----------------------------------------------------------------------
  // Answer holds its data; strobe lasts one cycle
  always_comb begin
    rd_data_next = rd_data_reg;
    rd_valid_next = 1'b0;
    if (do_rd) begin
      rd_data_next = slice;
      rd_valid_next = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Synchronous reset clears everything
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      acc_reg <= `DACC_ACC_RST;
      rd_data_reg <= `DACC_WORD_RST;
      rd_valid_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  // Outputs straight from flip-flops
  assign dsp_accumulator_o = acc_reg;
  assign rd_data_o = rd_data_reg;
  assign rd_valid_o = rd_valid_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_prod_overwrite: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) do_prod |=> acc_reg == $past(prod_data_i))
    else $error("product did not overwrite accumulator");

  a_wr_high: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    do_wr_hi |=> acc_reg[63:32] == $past(src_data_i))
    else $error("high write not stored");

  a_wr_high_keep: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    do_wr_hi |=> acc_reg[31:0] == $past(acc_reg[31:0]))
    else $error("high write disturbed low half");

  a_wr_low: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    do_wr_lo |=> acc_reg[31:0] == $past(src_data_i))
    else $error("low write not stored");

  a_wr_low_keep: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    do_wr_lo |=> acc_reg[63:32] == $past(acc_reg[63:32]))
    else $error("low write disturbed high half");

  a_rd_high: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    (op_valid_i && op_i == DACC_OP_RD_HIGH) |=>
      rd_valid_o && rd_data_o == $past(acc_reg[63:32]))
    else $error("high read wrong");

  a_rd_middle: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    (op_valid_i && op_i == DACC_OP_RD_MIDDLE) |=>
      rd_valid_o && rd_data_o == $past(acc_reg[47:16]))
    else $error("middle read wrong");

  a_rd_no_change: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    (do_rd || !op_valid_i) |=> $stable(acc_reg))
    else $error("accumulator changed without write");

  a_strobe_cause: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    rd_valid_o |-> $past(do_rd))
    else $error("read strobe without request");

  // ----------------------------------------------------------------------
  // Reset, hold and product assertions
  // ----------------------------------------------------------------------
  // Reset clears the accumulator at the next edge
  a_reset_acc: assert property (@(posedge core_clk_i)
    !rst_n_i |=> acc_reg == `DACC_ACC_RST)
    else $error("accumulator not cleared by reset");

  // Reset clears the read answer and its strobe
  a_reset_answer: assert property (@(posedge core_clk_i)
    !rst_n_i |=> !rd_valid_o && rd_data_o == `DACC_WORD_RST)
    else $error("read answer not cleared by reset");

  // No read request means no strobe next cycle
  a_rd_quiet: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    !do_rd |=> !rd_valid_o)
    else $error("read strobe without read");

  // Read data holds until the next read
  a_rd_data_hold: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    !do_rd |=> $stable(rd_data_o))
    else $error("read data moved without read");

  // A read leaves the visible accumulator alone
  a_rd_keeps_acc: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    do_rd |=> $stable(dsp_accumulator_o))
    else $error("read altered accumulator output");

  // Product result reaches the output port in full
  a_prod_output: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    do_prod |=> dsp_accumulator_o == $past(prod_data_i))
    else $error("product not on accumulator output");

  // Product taking no read strobe along
  a_prod_no_strobe: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    do_prod |=> !rd_valid_o)
    else $error("product raised read strobe");

endmodule : dacc_top

// ==== tb/dacc_mul_model.sv ====
// Multiply datapath model feeding full products to the accumulator
module dacc_mul_model (
  // Operands from the execution stage
  input wire logic [31:0] opa_i,
  input wire logic [31:0] opb_i,
  // Full 64-bit product
  output logic [63:0] prod_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Settled well before the edge that takes the product
  assign prod_o = {32'h0, opa_i} * {32'h0, opb_i};
endmodule : dacc_mul_model

// ==== tb/dsp_accumulator_register_tb.sv ====
// Self-checking bench for the DSP accumulator register
module dsp_accumulator_register_tb
  import dacc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Stimulus row: op, operands, expected contents and read answer
  typedef struct {
    dacc_op_t op;
    logic [31:0] a;
    logic [31:0] b;
    logic [63:0] acc;
    logic [31:0] rd;
  } dacc_row_t;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic op_valid_i = 1'b0;
  dacc_op_t op_i = DACC_OP_NONE;
  dacc_prod_t prod_kind_i = DACC_PR_SIGNED_WIDE;
  logic [31:0] src_data_i = 32'h0;
  logic [31:0] mul_b = 32'h0;
  logic [63:0] prod_data_i;
  logic [63:0] dsp_accumulator_o;
  logic [31:0] rd_data_o;
  logic rd_valid_o;
  int miscompares = 0;
  int samples_checked = 0;
  dacc_row_t rows[$];
  always #2 core_clk_i = ~core_clk_i;
  dacc_top u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .op_valid_i(op_valid_i), .op_i(op_i), .prod_kind_i(prod_kind_i),
    .src_data_i(src_data_i), .prod_data_i(prod_data_i),
    .dsp_accumulator_o(dsp_accumulator_o), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o));
  dacc_mul_model u_mul (.opa_i(src_data_i), .opb_i(mul_b),
    .prod_o(prod_data_i));
  // Compare one value, count it, report a difference
  task automatic chk(input string nm, input logic [63:0] exp,
    input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic add(input dacc_op_t op, input logic [31:0] a,
    input logic [31:0] b, input logic [63:0] acc, input logic [31:0] rd);
    rows.push_back('{op, a, b, acc, rd});
  endtask : add
  // Outputs one cycle after the row was taken
  task automatic check_row(input dacc_row_t r);
    logic rd;
    rd = (r.op == DACC_OP_RD_HIGH) || (r.op == DACC_OP_RD_MIDDLE);
    chk("accumulator", r.acc, dsp_accumulator_o);
    chk("read valid", {63'h0, rd}, {63'h0, rd_valid_o});
    if (rd) chk("read data", {32'h0, r.rd}, {32'h0, rd_data_o});
  endtask : check_row
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  initial begin
    // Products sit where index modulo 5 walks every product kind
    add(DACC_OP_PRODUCT, 32'hFFFFFFFF, 32'hFFFFFFFF,
      64'hFFFFFFFE00000001, 32'h0);
    add(DACC_OP_RD_HIGH, 32'h0, 32'h0, 64'hFFFFFFFE00000001, 32'hFFFFFFFE);
    add(DACC_OP_RD_MIDDLE, 32'h0, 32'h0, 64'hFFFFFFFE00000001, 32'hFFFE0000);
    add(DACC_OP_WR_LOW, 32'h12345678, 32'h0, 64'hFFFFFFFE12345678, 32'h0);
    add(DACC_OP_RD_MIDDLE, 32'h0, 32'h0, 64'hFFFFFFFE12345678, 32'hFFFE1234);
    add(DACC_OP_WR_HIGH, 32'hA5A50F0F, 32'h0, 64'hA5A50F0F12345678, 32'h0);
    add(DACC_OP_RD_HIGH, 32'h0, 32'h0, 64'hA5A50F0F12345678, 32'hA5A50F0F);
    add(DACC_OP_NONE, 32'hDEADBEEF, 32'h1, 64'hA5A50F0F12345678, 32'h0);
    add(DACC_OP_PRODUCT, 32'h00010000, 32'h3, 64'h0000000000030000, 32'h0);
    add(DACC_OP_PRODUCT, 32'h2, 32'h3, 64'h0000000000000006, 32'h0);
    add(DACC_OP_RD_MIDDLE, 32'h0, 32'h0, 64'h0000000000000006, 32'h0);
    add(DACC_OP_PRODUCT, 32'h80000000, 32'h2, 64'h0000000100000000, 32'h0);
    add(DACC_OP_PRODUCT, 32'h0000FFFF, 32'h00010000,
      64'h00000000FFFF0000, 32'h0);
    add(DACC_OP_RD_MIDDLE, 32'h0, 32'h0, 64'h00000000FFFF0000, 32'h0000FFFF);
    // Reset held three cycles, outputs cleared
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    #1;
    chk("reset accumulator", 64'h0, dsp_accumulator_o);
    chk("reset read data", 64'h0, {32'h0, rd_data_o});
    chk("reset read valid", 64'h0, {63'h0, rd_valid_o});
    $display("test reset done");
    // Back-to-back rows, one op every cycle
    for (int i = 0; i <= rows.size(); i++) begin
      @(posedge core_clk_i);
      op_valid_i <= (i < rows.size());
      if (i < rows.size()) begin
        op_i <= rows[i].op;
        prod_kind_i <= dacc_prod_t'(i % 5);
        src_data_i <= rows[i].a;
        mul_b <= rows[i].b;
      end
      #1;
      if (i > 0) check_row(rows[i-1]);
    end
    $display("test rows done");
    // Write request without valid is ignored
    @(posedge core_clk_i);
    op_i <= DACC_OP_WR_HIGH;
    src_data_i <= 32'h11111111;
    repeat (2) @(posedge core_clk_i);
    #1;
    chk("idle write", 64'h00000000FFFF0000, dsp_accumulator_o);
    // Reset in mid-run clears the accumulator
    @(posedge core_clk_i);
    rst_n_i <= 1'b0;
    @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    #1;
    chk("second reset", 64'h0, dsp_accumulator_o);
    chk("second reset valid", 64'h0, {63'h0, rd_valid_o});
    $display("test idle and reset done");
    stop_test();
  end
endmodule : dsp_accumulator_register_tb
